// File: design/hvss_top.sv
// hvac stage sequencer: debounce, blower priority, compressor staging, fans
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: requests need five seconds steady before acceptance
// RQ2: compressor relays start five seconds apart
// RQ3: pin or fieldbus bit gives request
// RQ4: fan-only runs blower at stage-two speed
// RQ5: any request starts blower at its speed; a reversing request alone leaves the blower at zero
// RQ6: blower priority y2, y1, aux, moist, fan
// RQ7: cooling-only never runs compressor with heater
// RQ8: heat pump allows compressor with heater
// RQ9: stage one and two speeds separately set
// RQ10: system type setting picks cooling sequence
// RQ11: stage one request energizes first compressor
// RQ12: two fixed compressors follow y1, y2
// RQ13: y2 with y1 adds second compressor
// RQ14: staged second compressor only with first
// RQ15: single-stage compressor runs full on y1
// RQ16: heat pump cooling needs reversing request
// RQ17: outdoor fan modulates toward 90F liquid
// RQ18: outdoor fan off below 80F, ramps above
// RQ19: above 115F outdoor fan at maximum
// RQ20: fixed-speed motor relay follows pressure switch
// RQ21: cooling drop stops compressors and fan
// RQ22: blower purges configured seconds after cooling
// RQ23: aux heat speed 70 to 100, default 100
// RQ24: moist speed 60 to 100, default 80
// RQ25: timers use one second tick, reset
// RQ26: blower percent output, zero when idle
module hvss_top
   import hvss_pkg::*;
#(
   parameter int TICK_CYC = hvss_pkg::HVSS_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [hvss_pkg::HVSS_NREQ-1:0] req_pin_i,
   input wire logic press_switch_i,
   input wire logic [7:0] liquid_temp_fan_control_input_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic compressor_first_relay_o,
   output logic compressor_second_relay_o,
   output logic reversing_valve_drive_o,
   output logic heater_o,
   output logic outdoor_fan_relay_output_o,
   output logic [7:0] outdoor_fan_speed_o,
   output logic [7:0] blower_speed_o
);
   import hvss_pkg::*;

   // pin and temperature synchronisers
   logic [HVSS_NREQ:0] pin_s1_ff, pin_s2_ff;
   logic [7:0] temp_s1_ff, temp_s2_ff;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         temp_s1_ff <= 8'h00;
         temp_s2_ff <= 8'h00;
      end else begin
         pin_s1_ff <= {press_switch_i, req_pin_i};
         pin_s2_ff <= pin_s1_ff;
         temp_s1_ff <= liquid_temp_fan_control_input_i;
         temp_s2_ff <= temp_s1_ff;
      end
   end

   // one-second tick
   logic [31:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick_ff, nxt_tick;
   always_comb begin
      nxt_tick = 1'b0;
      nxt_tick_cnt = tick_cnt_ff + 32'h1;
      if (tick_cnt_ff >= 32'(TICK_CYC - 1)) begin
         nxt_tick_cnt = 32'h0;
         nxt_tick = 1'b1; // RQ25
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // software registers
   logic [HVSS_NREQ-1:0] bus_req_ff, nxt_bus_req;
   hvss_cfg_t cfg_ff, nxt_cfg;
   hvss_spd_t spd_ff, nxt_spd;
   logic [7:0] purge_set_ff, nxt_purge_set;
   logic [7:0] odf_max_ff, nxt_odf_max;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [HVSS_NREQ-1:0] acc_ff;
   hvss_relay_t rly_ff;
   logic [7:0] blow_ff, odf_spd_ff;

   function automatic logic [7:0] clamp_pct(input logic [7:0] v, input logic [7:0] lo);
      clamp_pct = (v < lo) ? lo : ((v > HVSS_SPD_MAX) ? HVSS_SPD_MAX : v);
   endfunction

   always_comb begin
      nxt_bus_req = bus_req_ff;
      nxt_cfg = cfg_ff;
      nxt_spd = spd_ff;
      nxt_purge_set = purge_set_ff;
      nxt_odf_max = odf_max_ff;
      nxt_rdata = 32'h0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            HVSS_REQ_OFS: nxt_bus_req = reg_wdata_i[HVSS_NREQ-1:0];
            HVSS_CFG_OFS: nxt_cfg = reg_wdata_i[3:0]; // RQ10
            HVSS_SPD_OFS: begin
               nxt_spd.y1 = clamp_pct(reg_wdata_i[HVSS_SPD_Y1_LSB+:8], 8'h00); // RQ9
               nxt_spd.y2 = clamp_pct(reg_wdata_i[HVSS_SPD_Y2_LSB+:8], 8'h00); // RQ9
               nxt_spd.aux = clamp_pct(reg_wdata_i[HVSS_SPD_AUX_LSB+:8],
                                       HVSS_SPD_AUX_MIN); // RQ23
               nxt_spd.moist = clamp_pct(reg_wdata_i[HVSS_SPD_MOIST_LSB+:8],
                                         HVSS_SPD_MOIST_MIN); // RQ24
            end
            HVSS_PURGE_OFS: nxt_purge_set = reg_wdata_i[7:0];
            HVSS_ODF_OFS: nxt_odf_max = clamp_pct(reg_wdata_i[7:0], 8'h00);
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            HVSS_REQ_OFS: nxt_rdata = {26'h0, bus_req_ff};
            HVSS_CFG_OFS: nxt_rdata = {28'h0, cfg_ff};
            HVSS_SPD_OFS: nxt_rdata = spd_ff;
            HVSS_PURGE_OFS: nxt_rdata = {24'h0, purge_set_ff};
            HVSS_ODF_OFS: nxt_rdata = {24'h0, odf_max_ff};
            HVSS_STAT_OFS: nxt_rdata = {8'h0, blow_ff, 2'h0, acc_ff, 3'h0, rly_ff};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_req_ff <= '0;
         cfg_ff <= '0;
         spd_ff <= {HVSS_SPD_MOIST_RST, HVSS_SPD_AUX_RST, HVSS_SPD_Y2_RST, HVSS_SPD_Y1_RST};
         purge_set_ff <= HVSS_PURGE_RST;
         odf_max_ff <= HVSS_ODF_MAX_RST;
         rdata_ff <= 32'h0;
      end else begin
         bus_req_ff <= nxt_bus_req;
         cfg_ff <= nxt_cfg;
         spd_ff <= nxt_spd;
         purge_set_ff <= nxt_purge_set;
         odf_max_ff <= nxt_odf_max;
         rdata_ff <= nxt_rdata;
      end
   end

   // debounce: raw request must stay high five ticks; drop is immediate
   logic [HVSS_NREQ-1:0] raw_req, nxt_acc;
   logic [HVSS_NREQ-1:0][7:0] deb_ff, nxt_deb;
   assign raw_req = pin_s2_ff[HVSS_NREQ-1:0] | bus_req_ff; // RQ3
   always_comb begin
      for (int i = 0; i < HVSS_NREQ; i++) begin
         nxt_deb[i] = deb_ff[i];
         nxt_acc[i] = acc_ff[i];
         if (!raw_req[i]) begin
            nxt_deb[i] = 8'h00;
            nxt_acc[i] = 1'b0;
         end else if (tick_ff && !acc_ff[i]) begin
            nxt_deb[i] = deb_ff[i] + 8'h01;
            if (deb_ff[i] + 8'h01 >= HVSS_DEBOUNCE_S) begin
               nxt_acc[i] = 1'b1; // RQ1
            end
         end
      end
   end

   // compressor and output sequencing
   logic want1, want2, cool, y1, y2, aux, moist, fan, rev;
   logic [7:0] stag_ff, nxt_stag;
   logic [7:0] purge_ff, nxt_purge;
   logic was_cool_ff;
   hvss_relay_t nxt_rly;
   logic [7:0] nxt_blow, nxt_odf;
   assign y1 = acc_ff[HVSS_REQ_Y1];
   assign y2 = acc_ff[HVSS_REQ_Y2];
   assign aux = acc_ff[HVSS_REQ_AUX];
   assign moist = acc_ff[HVSS_REQ_MOIST];
   assign fan = acc_ff[HVSS_REQ_FAN];
   assign rev = acc_ff[HVSS_REQ_REV];

   always_comb begin
      want1 = 1'b0;
      want2 = 1'b0;
      case (cfg_ff.cmp) // RQ10
         HVSS_CMP_FIXED2: begin
            want1 = y1; // RQ12
            want2 = y2; // RQ12 RQ13
         end
         HVSS_CMP_STAGED: begin
            want1 = y1; // RQ11
            want2 = y1 && y2; // RQ14
         end
         HVSS_CMP_SINGLE: begin
            want1 = y1; // RQ15
            want2 = y1; // RQ15
         end
         default: want1 = y1; // RQ11
      endcase
      if (cfg_ff.hp && !rev) begin
         // heat pump cooling only with the reversing request
         want1 = 1'b0; // RQ16
         want2 = 1'b0;
      end
      // cooling-only: cooling wins and heat is held off
      cool = want1 || want2;
   end

   always_comb begin
      nxt_rly = rly_ff;
      nxt_stag = stag_ff;
      if (!cool) begin
         nxt_rly.cmp1 = 1'b0; // RQ21
         nxt_rly.cmp2 = 1'b0; // RQ21
         nxt_stag = 8'h00;
      end else begin
         if (!want1) nxt_rly.cmp1 = 1'b0;
         if (!want2) nxt_rly.cmp2 = 1'b0;
         // one relay closes per gap; the gap restarts after each closing
         if (tick_ff && stag_ff != 8'h00) nxt_stag = stag_ff - 8'h01;
         if (stag_ff == 8'h00) begin
            if (want1 && !rly_ff.cmp1) begin
               nxt_rly.cmp1 = 1'b1;
               nxt_stag = HVSS_STAGGER_S; // RQ2
            end else if (want2 && !rly_ff.cmp2) begin
               nxt_rly.cmp2 = 1'b1;
               nxt_stag = HVSS_STAGGER_S; // RQ2
            end
         end
         if (cfg_ff.cmp == HVSS_CMP_STAGED && !nxt_rly.cmp1) nxt_rly.cmp2 = 1'b0; // RQ14
      end
      nxt_rly.rev = cfg_ff.hp && rev && cool; // RQ16
      nxt_rly.heat = aux && (cfg_ff.hp || !cool); // RQ7 RQ8
      // fixed-speed outdoor motor relay tracks the pressure switch
      nxt_rly.odf_relay = cfg_ff.psc && cool && pin_s2_ff[HVSS_NREQ]; // RQ20 RQ21
      // modulating outdoor fan
      nxt_odf = 8'h00;
      if (cool && !cfg_ff.psc) begin
         if (temp_s2_ff > HVSS_LL_MAX_F) begin
            nxt_odf = odf_max_ff; // RQ19
         end else if (temp_s2_ff >= HVSS_LL_OFF_F) begin
            // two-slope ramp 80F..115F, half speed at the 90F target
            nxt_odf = (temp_s2_ff <= HVSS_LL_TARGET_F) ?
               8'((16'(temp_s2_ff - HVSS_LL_OFF_F) * 16'(odf_max_ff)) /
                  16'(2 * (HVSS_LL_TARGET_F - HVSS_LL_OFF_F))) :
               8'((16'(odf_max_ff) >> 1) +
                  (16'(temp_s2_ff - HVSS_LL_TARGET_F) * 16'(odf_max_ff)) /
                  16'(2 * (HVSS_LL_MAX_F - HVSS_LL_TARGET_F))); // RQ17 RQ18
         end
      end
      // purge timer after cooling ends
      nxt_purge = purge_ff;
      if (cool) begin
         nxt_purge = 8'h00;
      end else if (was_cool_ff) begin
         nxt_purge = purge_set_ff; // RQ22
      end else if (tick_ff && purge_ff != 8'h00) begin
         nxt_purge = purge_ff - 8'h01; // RQ22 RQ25
      end
      // blower priority
      if (y2) nxt_blow = spd_ff.y2; // RQ6 RQ9
      else if (y1) nxt_blow = spd_ff.y1; // RQ5 RQ9
      else if (aux) nxt_blow = spd_ff.aux; // RQ5 RQ23
      else if (moist) nxt_blow = spd_ff.moist; // RQ5 RQ24
      else if (fan) nxt_blow = spd_ff.y2; // RQ4
      else if (purge_ff != 8'h00 || was_cool_ff) nxt_blow = blow_ff; // RQ22
      else nxt_blow = 8'h00; // RQ26
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         deb_ff <= '0;
         acc_ff <= '0;
         rly_ff <= '0;
         stag_ff <= 8'h00;
         purge_ff <= 8'h00;
         was_cool_ff <= 1'b0;
         blow_ff <= 8'h00;
         odf_spd_ff <= 8'h00;
      end else begin
         deb_ff <= nxt_deb;
         acc_ff <= nxt_acc;
         rly_ff <= nxt_rly;
         stag_ff <= nxt_stag;
         purge_ff <= nxt_purge;
         was_cool_ff <= cool;
         blow_ff <= nxt_blow;
         odf_spd_ff <= nxt_odf;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign compressor_first_relay_o = rly_ff.cmp1;
   assign compressor_second_relay_o = rly_ff.cmp2;
   assign reversing_valve_drive_o = rly_ff.rev;
   assign heater_o = rly_ff.heat;
   assign outdoor_fan_relay_output_o = rly_ff.odf_relay;
   assign outdoor_fan_speed_o = odf_spd_ff;
   assign blower_speed_o = blow_ff;
endmodule // hvss_top
`default_nettype wire

// File: inc/hvss_pkg.sv
// package for the hvac stage sequencer: map, fields, timing and types
package hvss_pkg;
   // register byte offsets
   localparam logic [7:0] HVSS_REQ_OFS = 8'h00;
   localparam logic [7:0] HVSS_CFG_OFS = 8'h04;
   localparam logic [7:0] HVSS_SPD_OFS = 8'h08;
   localparam logic [7:0] HVSS_PURGE_OFS = 8'h0c;
   localparam logic [7:0] HVSS_STAT_OFS = 8'h10;
   localparam logic [7:0] HVSS_ODF_OFS = 8'h14;
   // request bit positions, shared by pins and the fieldbus register
   localparam int HVSS_REQ_FAN = 0;
   localparam int HVSS_REQ_Y1 = 1;
   localparam int HVSS_REQ_Y2 = 2;
   localparam int HVSS_REQ_AUX = 3;
   localparam int HVSS_REQ_MOIST = 4;
   localparam int HVSS_REQ_REV = 5;
   localparam int HVSS_NREQ = 6;
   // config register fields
   localparam int HVSS_CFG_HP = 0;
   localparam int HVSS_CFG_CMP_LSB = 1;
   localparam int HVSS_CFG_PSC = 3;
   // speed register fields (percent, 8 bits each)
   localparam int HVSS_SPD_Y1_LSB = 0;
   localparam int HVSS_SPD_Y2_LSB = 8;
   localparam int HVSS_SPD_AUX_LSB = 16;
   localparam int HVSS_SPD_MOIST_LSB = 24;
   // reset values and speed limits
   localparam logic [7:0] HVSS_SPD_Y1_RST = 8'h46;
   localparam logic [7:0] HVSS_SPD_Y2_RST = 8'h64;
   localparam logic [7:0] HVSS_SPD_AUX_RST = 8'h64;
   localparam logic [7:0] HVSS_SPD_MOIST_RST = 8'h50;
   localparam logic [7:0] HVSS_SPD_AUX_MIN = 8'h46;
   localparam logic [7:0] HVSS_SPD_MOIST_MIN = 8'h3c;
   localparam logic [7:0] HVSS_SPD_MAX = 8'h64;
   localparam logic [7:0] HVSS_ODF_MAX_RST = 8'h64;
   localparam logic [7:0] HVSS_PURGE_RST = 8'h5a;
   // liquid line thresholds, degrees F
   localparam logic [7:0] HVSS_LL_OFF_F = 8'h50;
   localparam logic [7:0] HVSS_LL_TARGET_F = 8'h5a;
   localparam logic [7:0] HVSS_LL_MAX_F = 8'h73;
   // timing
   localparam int HVSS_CLK_HZ = 200_000_000;
   localparam int HVSS_TICK_S = 1;
   localparam int HVSS_TICK_CYC = HVSS_CLK_HZ * HVSS_TICK_S;
   localparam logic [7:0] HVSS_DEBOUNCE_S = 8'h05;
   localparam logic [7:0] HVSS_STAGGER_S = 8'h05;

   typedef enum logic [1:0] {
      HVSS_CMP_FIXED1 = 2'h0,
      HVSS_CMP_FIXED2 = 2'h1,
      HVSS_CMP_STAGED = 2'h2,
      HVSS_CMP_SINGLE = 2'h3
   } hvss_cmp_t;

   typedef struct packed {
      logic [7:0] moist;
      logic [7:0] aux;
      logic [7:0] y2;
      logic [7:0] y1;
   } hvss_spd_t;

   typedef struct packed {
      logic psc;
      hvss_cmp_t cmp;
      logic hp;
   } hvss_cfg_t;

   typedef struct packed {
      logic cmp1;
      logic cmp2;
      logic rev;
      logic heat;
      logic odf_relay;
   } hvss_relay_t;
endpackage

// File: sim/hvss_sva.sv
// checker for the stage sequencer ports
`timescale 1ns/1ps
`default_nettype none
module hvss_sva
   import hvss_pkg::*;
#(
   parameter int TICK_CYC = 10
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [hvss_pkg::HVSS_NREQ-1:0] req_pin_i,
   input wire logic [7:0] liquid_temp_fan_control_input_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic compressor_first_relay_o,
   input wire logic compressor_second_relay_o,
   input wire logic heater_o,
   input wire logic [7:0] outdoor_fan_speed_o,
   input wire logic [7:0] blower_speed_o
);
   logic [5:0] fb_ff;
   logic [3:0] cfg_ff;
   logic [7:0] max_ff;
   logic [15:0] cool_ff;
   logic [15:0] c1_ff;
   wire logic [5:0] req = req_pin_i | fb_ff;
   wire logic cool = req[HVSS_REQ_Y1] | req[HVSS_REQ_Y2];
   wire logic c1 = compressor_first_relay_o;
   wire logic c2 = compressor_second_relay_o;
   wire logic [7:0] ll = liquid_temp_fan_control_input_i;
   // shadows of the request, config and fan-max fields, so rules can be judged from the ports alone
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fb_ff <= '0;
         cfg_ff <= '0;
         max_ff <= 8'h64;
         cool_ff <= '0;
         c1_ff <= '0;
      end else begin
         if (reg_wr_i && reg_addr_i == HVSS_REQ_OFS) fb_ff <= reg_wdata_i[5:0];
         if (reg_wr_i && reg_addr_i == HVSS_CFG_OFS) cfg_ff <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == HVSS_ODF_OFS) max_ff <= reg_wdata_i[7:0];
         cool_ff <= cool ? cool_ff + 16'(cool_ff != '1) : '0;
         c1_ff <= c1 ? c1_ff + 16'(c1_ff != '1) : '0;
      end
   end
   sequence s_cool_idle;
      (!cool)[*5];
   endsequence
   sequence s_hot;
      (c1 && !cfg_ff[3] && ll > 8'h73 && !reg_wr_i)[*5];
   endsequence
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_rd_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_debounce;
      $rose(c1) |-> cool_ff >= 16'(4 * TICK_CYC);
   endproperty
   a_debounce: assert property (p_debounce) else $error("compressor before debounce");
   property p_stagger;
      $rose(c2) && c1 |-> c1_ff >= 16'(4 * TICK_CYC);
   endproperty
   a_stagger: assert property (p_stagger) else $error("compressors too close");
   property p_ac_excl;
      !cfg_ff[0] |-> !(heater_o && (c1 || c2));
   endproperty
   a_ac_excl: assert property (p_ac_excl) else $error("heater with compressor");
   property p_staged;
      cfg_ff[2:1] == 2'h2 && c2 |-> c1;
   endproperty
   a_staged: assert property (p_staged) else $error("second stage alone");
   property p_hp_norev;
      (cfg_ff[0] && !req[HVSS_REQ_REV])[*5] |-> !c1 && !c2;
   endproperty
   a_hp_norev: assert property (p_hp_norev) else $error("cooling without valve");
   property p_odf_low;
      (ll < 8'h50)[*5] |-> outdoor_fan_speed_o == 8'h00;
   endproperty
   a_odf_low: assert property (p_odf_low) else $error("fan on below low limit");
   property p_odf_high;
      s_hot |-> outdoor_fan_speed_o == max_ff;
   endproperty
   a_odf_high: assert property (p_odf_high) else $error("fan not at max");
   property p_drop;
      s_cool_idle |-> !c1 && !c2 && outdoor_fan_speed_o == 8'h00;
   endproperty
   a_drop: assert property (p_drop) else $error("cooling outputs stuck");
   property p_blower;
      $rose(c1) |-> blower_speed_o != 8'h00;
   endproperty
   a_blower: assert property (p_blower) else $error("compressor without blower");
endmodule // hvss_sva
bind hvss_top hvss_sva #(.TICK_CYC(TICK_CYC)) i_hvss_sva (.clk_i, .sys_rst_i, .req_pin_i,
   .liquid_temp_fan_control_input_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .compressor_first_relay_o, .compressor_second_relay_o, .heater_o,
   .outdoor_fan_speed_o, .blower_speed_o);
`default_nettype wire

// File: sim/hvss_tb_top.sv
// testbench for the hvac stage sequencer
`timescale 1ns/1ps
`default_nettype none
module hvss_tb_top;
   import hvss_pkg::*;
   localparam int TK = 10;
   logic clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, psw = 0, hp = 0, omit = 0;
   logic [5:0] call = 0, pins;
   logic [7:0] addr = 0, ll = 8'h5a, ofs, bl;
   logic [31:0] wd = 0, rdata;
   logic c1, c2, rv, ht, outdoor_fan_relay_output;
   int n_fail = 0, comparisons = 0;
   always #2.5 clk_i = ~clk_i;
   hvss_tstat i_hvss_tstat (.clk_i, .call_i(call), .hp_i(hp), .omit_rev_i(omit), .req_o(pins));
   hvss_top #(.TICK_CYC(TK)) i_hvss_top (.clk_i, .sys_rst_i, .req_pin_i(pins),
      .press_switch_i(psw), .liquid_temp_fan_control_input_i(ll), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .compressor_first_relay_o(c1), .compressor_second_relay_o(c2),
      .reversing_valve_drive_o(rv), .heater_o(ht), .outdoor_fan_relay_output_o(outdoor_fan_relay_output),
      .outdoor_fan_speed_o(ofs), .blower_speed_o(bl));
   task automatic summarize();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(string nm, logic [7:0] a, logic [31:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(nm, exp, rdata);
   endtask
   // drive the stat on an edge so the pins change on the next edge
   task automatic stat(logic [5:0] v);
      @(posedge clk_i);
      call <= v;
   endtask
   task automatic wait_c1(int lim);
      int i;
      // look after the edge has settled, never in the launching time step
      for (i = 0; i < lim && c1 !== 1'b1; i++) cyc(1);
      if (c1 !== 1'b1) begin
         chk("c1 wait", 1, 0);
         summarize();
      end
   endtask
   task automatic t_regs();
      rreg("speeds", HVSS_SPD_OFS, 32'h50646446);
      rreg("purge", HVSS_PURGE_OFS, 32'h5a);
      rreg("odf max", HVSS_ODF_OFS, 32'h64);
      rreg("unmapped", 8'h20, 32'h0);
      chk("idle blower", 0, bl);
   endtask
   task automatic t_fan();
      wreg(HVSS_CFG_OFS, 32'h0);
      wreg(HVSS_SPD_OFS, 32'h50645a3c);
      wreg(HVSS_PURGE_OFS, 32'h3);
      stat(6'h01);
      cyc(7 * TK);
      chk("fan only", 8'h5a, bl);
      wreg(HVSS_REQ_OFS, 32'h10);
      cyc(7 * TK);
      chk("moist", 8'h50, bl);
      stat(6'h09);
      cyc(7 * TK);
      chk("aux", 8'h64, bl);
      stat(6'h0b);
      cyc(7 * TK);
      chk("y1 blower", 8'h3c, bl);
      chk("y1 cmp", 1, c1);
      chk("ac heat", 0, ht);
      stat(6'h00);
      wreg(HVSS_REQ_OFS, 32'h0);
      cyc(TK);
      chk("purge on", 8'h3c, bl);
      cyc(6 * TK);
      chk("purge off", 0, bl);
   endtask
   task automatic t_staged();
      wreg(HVSS_CFG_OFS, 32'h4);
      stat(6'h06);
      cyc(7 * TK);
      chk("stg c1", 1, c1);
      chk("stg c2 gap", 0, c2);
      chk("y2 blower", 8'h5a, bl);
      chk("odf 90F", 8'h32, ofs);
      cyc(6 * TK);
      chk("stg c2", 1, c2);
      ll <= 8'h46;
      cyc(6);
      chk("odf cold", 0, ofs);
      ll <= 8'h78;
      cyc(6);
      chk("odf hot", 8'h64, ofs);
      wreg(HVSS_ODF_OFS, 32'h50);
      cyc(6);
      chk("odf cfg max", 8'h50, ofs);
      ll <= 8'h5a;
      stat(6'h00);
      cyc(6);
      chk("drop c1", 0, c1);
      chk("drop odf", 0, ofs);
      cyc(7 * TK);
   endtask
   task automatic t_fixed2();
      wreg(HVSS_CFG_OFS, 32'h2);
      wreg(HVSS_REQ_OFS, 32'h04);
      cyc(7 * TK);
      chk("fx2 c2", 1, c2);
      chk("fx2 c1", 0, c1);
      wreg(HVSS_REQ_OFS, 32'h0);
      cyc(7 * TK);
   endtask
   task automatic t_hp();
      hp <= 1'b1;
      omit <= 1'b1;
      wreg(HVSS_CFG_OFS, 32'h1);
      stat(6'h02);
      cyc(7 * TK);
      chk("hp no valve", 0, c1);
      omit <= 1'b0;
      wait_c1(10 * TK);
      cyc(1);
      chk("hp valve", 1, rv);
      stat(6'h0a);
      cyc(14 * TK);
      chk("hp heat", 1, ht);
      chk("hp cmp", 1, c1);
      stat(6'h00);
      hp <= 1'b0;
      cyc(7 * TK);
   endtask
   task automatic t_single();
      wreg(HVSS_CFG_OFS, 32'h6);
      stat(6'h02);
      cyc(7 * TK);
      chk("sgl c1", 1, c1);
      chk("sgl c2 gap", 0, c2);
      cyc(6 * TK);
      chk("sgl c2", 1, c2);
      stat(6'h00);
      cyc(7 * TK);
   endtask
   task automatic t_psc();
      wreg(HVSS_CFG_OFS, 32'h8);
      psw <= 1'b1;
      stat(6'h02);
      cyc(7 * TK);
      chk("ofr closed", 1, outdoor_fan_relay_output);
      psw <= 1'b0;
      cyc(6);
      chk("ofr open", 0, outdoor_fan_relay_output);
      stat(6'h00);
      cyc(TK);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_regs();
      t_fan();
      t_staged();
      t_fixed2();
      t_hp();
      t_single();
      t_psc();
      summarize();
   end
endmodule // hvss_tb_top
`default_nettype wire

// File: sim/hvss_tstat.sv
// wall thermostat model driving the discrete request pins
`timescale 1ns/1ps
`default_nettype none
module hvss_tstat (
   input wire logic clk_i,
   input wire logic [5:0] call_i,
   input wire logic hp_i,
   input wire logic omit_rev_i,
   output logic [5:0] req_o
);
   always_ff @(posedge clk_i) begin
      req_o <= call_i;
      // a heat pump stat pairs cooling with the valve call unless told to misbehave
      if (hp_i && !omit_rev_i && (call_i[1] || call_i[2])) req_o[5] <= 1'b1;
   end
endmodule // hvss_tstat
`default_nettype wire
